/* npf_pkg.sv */
// constants, types and helpers shared by the packet framer
// assumes a byte-wide link and a single clock
`default_nettype none

package npf_pkg;
   localparam int unsigned HDR_BYTES = 5;
   localparam logic [15:0] CRC_SEED = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] LRC_XOR = 8'hff;
   localparam logic [7:0] LRC_INC = 8'h01;
   localparam logic [7:0] ID_ACK = 8'h00;
   localparam logic [7:0] ID_REQ = 8'h01;
   localparam logic [7:0] ID_STATE_LO = 8'h14;
   localparam logic [7:0] ID_CFG_LO = 8'hb4;
   localparam logic [7:0] ACK_LEN = 8'h04;
   localparam logic [7:0] DEF_ID0 = 8'h14;
   localparam logic [7:0] DEF_ID1 = 8'h1c;
   localparam logic [15:0] DEF_PERIOD_MS = 16'h0032;
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   localparam int unsigned RX_DEPTH = 512;
   localparam int unsigned SLOTS = 2;

   typedef enum logic [7:0] {
      ACK_OK, ACK_CRC, ACK_SIZE, ACK_RANGE, ACK_FLASH, ACK_NREADY, ACK_UNKNOWN
   } npf_ack_t;
   typedef enum logic [1:0] {CL_SYS, CL_STATE, CL_CFG} npf_class_t;
   typedef struct packed {logic valid; logic [7:0] data;} npf_byte_t;
   typedef struct packed {logic [7:0] id; logic [7:0] len; logic [15:0] crc;} npf_hdr_t;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      return r;
   endfunction

   function automatic logic [7:0] lrc(input logic [7:0] id, input logic [7:0] len, input logic [15:0] c);
      logic [7:0] s;
      s = id + len + c[7:0] + c[15:8];
      return (s ^ LRC_XOR) + LRC_INC;
   endfunction

   function automatic npf_class_t class_of(input logic [7:0] id);
      if (id >= ID_CFG_LO) return CL_CFG;
      if (id >= ID_STATE_LO) return CL_STATE;
      return CL_SYS;
   endfunction
endpackage
`default_nettype wire

/* npf_crc.sv */
// byte-wise payload check accumulator
// assumes clr and en are never needed in the same cycle
`timescale 1ns/1ns
`default_nettype none

module npf_crc (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // byte feed
   input wire logic clr,
   input wire logic en,
   input wire logic [7:0] data,
   // running check value
   output logic [15:0] crc
);
   always_ff @(posedge mclk) begin
      if (!rstn || clr) crc <= npf_pkg::CRC_SEED;
      else if (en) crc <= npf_pkg::crc_step(crc, data);
   end

   a_crc_seed: assert property (@(posedge mclk) disable iff (!rstn) clr |=> crc == 16'hffff)
      else $error("check value not seeded after clear");
endmodule // npf_crc
`default_nettype wire

/* npf_sched.sv */
// periodic output slots; a due set forms one sequence served lowest id first
// assumes the consumer takes one id per seq_take pulse
`timescale 1ns/1ns
`default_nettype none

module npf_sched #(
   parameter int unsigned SLOTS = npf_pkg::SLOTS,
   parameter int unsigned TICK_CYC = npf_pkg::TICK_CYC,
   localparam int SW = $clog2(SLOTS)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // slot setup
   input wire logic cfg_wr,
   input wire logic [SW-1:0] cfg_slot,
   input wire logic [7:0] cfg_id,
   input wire logic [15:0] cfg_period,
   // sequence out
   input wire logic seq_take,
   output logic seq_valid,
   output logic [7:0] seq_id,
   output logic tov_strobe
);
   localparam int TW = $clog2(TICK_CYC);
   logic [TW-1:0] tc_q;
   logic [7:0] id_q [SLOTS];
   logic [15:0] per_q [SLOTS];
   logic [15:0] cnt_q [SLOTS];
   logic [SLOTS-1:0] due_q, seq_q, fire, take_m;
   logic [7:0] last_q;
   logic last_v_q;
   wire tick = tc_q == TW'(TICK_CYC - 1);
   wire start = (seq_q == '0) && (due_q != '0);

   always_comb begin
      seq_id = 8'hff;
      take_m = '0;
      for (int i = 0; i < SLOTS; i++) begin
         fire[i] = tick && (per_q[i] != 16'h0000) && (cnt_q[i] >= per_q[i] - 16'h0001);
         if (seq_q[i] && (take_m == '0 || id_q[i] < seq_id)) begin
            seq_id = id_q[i];
            take_m = SLOTS'(1) << i;
         end
      end
   end
   assign seq_valid = seq_q != '0;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tc_q <= '0;
         due_q <= '0;
         seq_q <= '0;
         tov_strobe <= 1'b0;
         for (int i = 0; i < SLOTS; i++) begin
            id_q[i] <= (i == 0) ? npf_pkg::DEF_ID0 : (i == 1) ? npf_pkg::DEF_ID1 : 8'h00;
            per_q[i] <= (i < 2) ? npf_pkg::DEF_PERIOD_MS : 16'h0000;
            cnt_q[i] <= '0;
         end
      end else begin
         tc_q <= tick ? '0 : tc_q + 1'b1;
         tov_strobe <= start;
         due_q <= start ? fire : (due_q | fire);
         seq_q <= start ? due_q : (seq_q & ~(seq_take ? take_m : '0));
         for (int i = 0; i < SLOTS; i++) begin
            if (cfg_wr && cfg_slot == SW'(i)) begin
               id_q[i] <= cfg_id;
               per_q[i] <= cfg_period;
               cnt_q[i] <= '0;
            end else if (tick && per_q[i] != 16'h0000) begin
               cnt_q[i] <= fire[i] ? 16'h0000 : cnt_q[i] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         last_q <= 8'h00;
         last_v_q <= 1'b0;
      end else begin
         last_v_q <= start ? 1'b0 : (last_v_q | seq_take);
         if (seq_take) last_q <= seq_id;
      end
   end

   a_seq_ascend: assert property (@(posedge mclk) disable iff (!rstn)
      (seq_take && last_v_q && !start) |-> seq_id >= last_q)
      else $error("sequence not in ascending id order");
   a_tov_first: assert property (@(posedge mclk) disable iff (!rstn)
      tov_strobe |-> (seq_valid && !$past(seq_valid)))
      else $error("validity strobe not at sequence start");
endmodule // npf_sched
`default_nettype wire

/* npf_framer.sv */
// binary packet framer and deframer for the nav_packet_protocol
// assumes a byte link in each direction and a device side that answers requests
`timescale 1ns/1ns
`default_nettype none

module npf_framer #(
   parameter int unsigned RX_DEPTH = npf_pkg::RX_DEPTH,
   parameter int unsigned TICK_CYC = npf_pkg::TICK_CYC,
   parameter int unsigned SLOTS = npf_pkg::SLOTS,
   localparam int SW = $clog2(SLOTS)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // byte link from host
   input wire npf_pkg::npf_byte_t rx_in,
   // byte link to host
   output var npf_pkg::npf_byte_t tx_out,
   input wire logic tx_ready,
   // received packets to device
   output var npf_pkg::npf_hdr_t rx_hdr,
   output logic rx_hdr_valid,
   output var npf_pkg::npf_class_t rx_class,
   output var npf_pkg::npf_byte_t rx_pay,
   // outcome of a delivered packet
   input wire logic res_valid,
   input wire logic [7:0] res_code,
   // payload source for transmission
   output logic src_req,
   output logic [7:0] src_id,
   input wire logic src_ack,
   input wire logic [7:0] src_len,
   input wire npf_pkg::npf_byte_t src_byte,
   // periodic schedule
   output logic tov_strobe,
   input wire logic cfg_wr,
   input wire logic [SW-1:0] cfg_slot,
   input wire logic [7:0] cfg_id,
   input wire logic [15:0] cfg_period
);
   localparam int AW = $clog2(RX_DEPTH);
   localparam logic [AW-1:0] HDR_N = AW'(npf_pkg::HDR_BYTES);

   typedef enum logic [1:0] {R_SCAN, R_CRC, R_OUT} npf_rx_st_t;
   typedef enum logic [2:0] {T_IDLE, T_REQ, T_LOAD, T_HDR, T_PAY} npf_tx_st_t;

   // receive window
   logic [7:0] rbuf_q [RX_DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   npf_rx_st_t rst_q;
   logic [7:0] j_q;
   npf_pkg::npf_hdr_t hdr_q;
   logic [15:0] rx_crc;

   function automatic logic [AW-1:0] rb(input logic [AW-1:0] base, input logic [AW-1:0] ofs);
      return base + ofs;
   endfunction

   function automatic logic [7:0] lowest(input logic [255:0] m);
      lowest = 8'h00;
      for (int i = 255; i >= 0; i--) if (m[i]) lowest = 8'(i);
   endfunction

   wire [AW-1:0] fill = wr_q - rd_q;
   wire rx_take = rx_in.valid && (fill != AW'(RX_DEPTH - 1));
   wire [7:0] h_id = rbuf_q[rb(rd_q, AW'(1))];
   wire [7:0] h_len = rbuf_q[rb(rd_q, AW'(2))];
   wire [15:0] h_crc = {rbuf_q[rb(rd_q, AW'(4))], rbuf_q[rb(rd_q, AW'(3))]};
   wire lrc_ok = rbuf_q[rd_q] == npf_pkg::lrc(h_id, h_len, h_crc);
   wire hdr_avail = fill >= HDR_N;
   wire [AW-1:0] pay_ofs = HDR_N + AW'(j_q);
   wire [7:0] pay_byte = rbuf_q[rb(rd_q, pay_ofs)];
   wire pay_avail = fill > pay_ofs;
   wire j_end = j_q == hdr_q.len;
   wire crc_good = rx_crc == hdr_q.crc;
   wire is_req = hdr_q.id == npf_pkg::ID_REQ;
   wire found = (rst_q == R_SCAN) && hdr_avail && lrc_ok;
   wire crc_en = (rst_q == R_CRC) && !j_end && pay_avail;
   wire rx_good = (rst_q == R_CRC) && j_end && crc_good;
   wire out_byte = (rst_q == R_OUT) && !j_end;

   always_ff @(posedge mclk) begin
      if (rx_take) rbuf_q[wr_q] <= rx_in.data;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         rst_q <= R_SCAN;
         j_q <= 8'h00;
         hdr_q <= '0;
      end else begin
         if (rx_take) wr_q <= wr_q + 1'b1;
         case (rst_q)
            R_SCAN: begin
               if (found) begin
                  hdr_q <= '{id: h_id, len: h_len, crc: h_crc};
                  j_q <= 8'h00;
                  rst_q <= R_CRC;
               end else if (hdr_avail) begin
                  rd_q <= rd_q + 1'b1;
               end
            end
            R_CRC: begin
               if (j_end) begin
                  j_q <= 8'h00;
                  if (crc_good) begin
                     rst_q <= R_OUT;
                  end else begin
                     rd_q <= rd_q + 1'b1;
                     rst_q <= R_SCAN;
                  end
               end else if (pay_avail) begin
                  j_q <= j_q + 8'h01;
               end
            end
            R_OUT: begin
               if (j_end) begin
                  rd_q <= rd_q + pay_ofs;
                  rst_q <= R_SCAN;
               end else begin
                  j_q <= j_q + 8'h01;
               end
            end
            default: rst_q <= R_SCAN;
         endcase
      end
   end

   npf_crc u_rx_crc (
      .mclk(mclk),
      .rstn(rstn),
      .clr(found),
      .en(crc_en),
      .data(pay_byte),
      .crc(rx_crc)
   );

   // delivery to the device
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_hdr <= '0;
         rx_hdr_valid <= 1'b0;
         rx_class <= npf_pkg::CL_SYS;
         rx_pay <= '0;
      end else begin
         rx_hdr_valid <= rx_good && !is_req;
         if (rx_good) begin
            rx_hdr <= hdr_q;
            rx_class <= npf_pkg::class_of(hdr_q.id);
         end
         rx_pay <= '{valid: out_byte && !is_req, data: pay_byte};
      end
   end

   // requests and acknowledgements
   logic [255:0] req_q, req_set, req_clr;
   npf_pkg::npf_hdr_t ctx_q;
   logic ctx_cfg_q, ack_pend_q;
   logic [7:0] ack_code_q;
   logic [15:0] ack_crc_q;
   logic [7:0] ack_id_q;
   wire ack_need = res_valid && (ctx_cfg_q || res_code != npf_pkg::ACK_OK);
   wire req_any = req_q != '0;
   wire [7:0] req_id = lowest(req_q);

   always_comb begin
      req_set = '0;
      if (out_byte && is_req && pay_byte >= npf_pkg::ID_STATE_LO) req_set[pay_byte] = 1'b1;
   end

   // transmit engine
   npf_tx_st_t tst_q;
   logic [7:0] tbuf_q [256];
   logic [7:0] tx_id_q, tx_len_q, k_q;
   logic is_ack_q;
   logic [31:0] ackd_q;
   logic [15:0] tx_crc;
   logic seq_valid;
   logic [7:0] seq_id;
   logic [8:0] nbytes_q;
   wire idle = tst_q == T_IDLE;
   wire seq_take = idle && seq_valid;
   wire ack_take = idle && !seq_valid && ack_pend_q;
   wire req_take = idle && !seq_valid && !ack_pend_q && req_any;
   wire ld_end = k_q == tx_len_q;
   wire [7:0] ack_byte = ackd_q[8 * k_q[1:0] +: 8];
   wire ld_v = is_ack_q || src_byte.valid;
   wire [7:0] ld_d = is_ack_q ? ack_byte : src_byte.data;
   wire tx_ld = (tst_q == T_LOAD) && !ld_end && ld_v;
   wire load_en = !tx_out.valid || tx_ready;
   wire tx_load = load_en && ((tst_q == T_HDR) || (tst_q == T_PAY && !ld_end));
   logic [7:0] hbyte;

   always_comb begin
      req_clr = '0;
      if (req_take) req_clr[req_id] = 1'b1;
      case (k_q)
         8'h00: hbyte = npf_pkg::lrc(tx_id_q, tx_len_q, tx_crc);
         8'h01: hbyte = tx_id_q;
         8'h02: hbyte = tx_len_q;
         8'h03: hbyte = tx_crc[7:0];
         default: hbyte = tx_crc[15:8];
      endcase
   end
   wire [7:0] tx_next = (tst_q == T_HDR) ? hbyte : tbuf_q[k_q];

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         req_q <= '0;
         ctx_q <= '0;
         ctx_cfg_q <= 1'b0;
         ack_pend_q <= 1'b0;
         ack_code_q <= 8'h00;
         ack_id_q <= 8'h00;
         ack_crc_q <= 16'h0000;
      end else begin
         req_q <= (req_q & ~req_clr) | req_set;
         if (rx_good && !is_req) begin
            ctx_q <= hdr_q;
            ctx_cfg_q <= npf_pkg::class_of(hdr_q.id) == npf_pkg::CL_CFG;
         end
         if (ack_need) begin
            ack_pend_q <= 1'b1;
            ack_code_q <= res_code;
            ack_id_q <= ctx_q.id;
            ack_crc_q <= ctx_q.crc;
         end else if (ack_take) begin
            ack_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (tx_ld) tbuf_q[k_q] <= ld_d;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tst_q <= T_IDLE;
         tx_id_q <= 8'h00;
         tx_len_q <= 8'h00;
         k_q <= 8'h00;
         is_ack_q <= 1'b0;
         ackd_q <= 32'h0000_0000;
      end else begin
         case (tst_q)
            T_IDLE: begin
               k_q <= 8'h00;
               if (seq_take || req_take) begin
                  tx_id_q <= seq_take ? seq_id : req_id;
                  is_ack_q <= 1'b0;
                  tst_q <= T_REQ;
               end else if (ack_take) begin
                  tx_id_q <= npf_pkg::ID_ACK;
                  tx_len_q <= npf_pkg::ACK_LEN;
                  ackd_q <= {ack_code_q, ack_crc_q[15:8], ack_crc_q[7:0], ack_id_q};
                  is_ack_q <= 1'b1;
                  tst_q <= T_LOAD;
               end
            end
            T_REQ: begin
               if (src_ack) begin
                  tx_len_q <= src_len;
                  tst_q <= T_LOAD;
               end
            end
            T_LOAD: begin
               if (ld_end) begin
                  k_q <= 8'h00;
                  tst_q <= T_HDR;
               end else if (ld_v) begin
                  k_q <= k_q + 8'h01;
               end
            end
            T_HDR: begin
               if (tx_load) begin
                  k_q <= (k_q == 8'h04) ? 8'h00 : k_q + 8'h01;
                  if (k_q == 8'h04) tst_q <= T_PAY;
               end
            end
            T_PAY: begin
               if (ld_end) tst_q <= T_IDLE;
               else if (tx_load) k_q <= k_q + 8'h01;
            end
            default: tst_q <= T_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) tx_out <= '0;
      else if (load_en) tx_out <= '{valid: tx_load, data: tx_next};
   end

   assign src_req = tst_q == T_REQ;
   assign src_id = tx_id_q;

   npf_crc u_tx_crc (
      .mclk(mclk),
      .rstn(rstn),
      .clr(idle),
      .en(tx_ld),
      .data(ld_d),
      .crc(tx_crc)
   );

   npf_sched #(
      .SLOTS(SLOTS),
      .TICK_CYC(TICK_CYC)
   ) u_sched (
      .mclk(mclk),
      .rstn(rstn),
      .cfg_wr(cfg_wr),
      .cfg_slot(cfg_slot),
      .cfg_id(cfg_id),
      .cfg_period(cfg_period),
      .seq_take(seq_take),
      .seq_valid(seq_valid),
      .seq_id(seq_id),
      .tov_strobe(tov_strobe)
   );

   // bytes loaded per frame, for checking
   always_ff @(posedge mclk) begin
      if (!rstn || idle) nbytes_q <= 9'h000;
      else if (tx_load) nbytes_q <= nbytes_q + 9'h001;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_bad_frame;
      rst_q == R_CRC && j_end && !crc_good;
   endsequence
   sequence s_rescan;
      rst_q == R_SCAN && rd_q == AW'($past(rd_q) + 1'b1);
   endsequence

   a_hdr_found: assert property (found |=> rst_q == R_CRC && hdr_q.id == $past(h_id))
      else $error("valid header not taken");
   a_lrc_skip: assert property ((rst_q == R_SCAN && hdr_avail && !lrc_ok) |=> s_rescan)
      else $error("bad header start not skipped by one");
   a_bad_crc_drop: assert property (s_bad_frame |=> s_rescan ##0 !rx_hdr_valid)
      else $error("bad frame not dropped or rescan wrong");
   a_good_deliver: assert property ((rx_good && !is_req) |=> rx_hdr_valid ##1 (j_q != 8'h00 || rx_hdr.len == 8'h00))
      else $error("good frame not delivered");
   a_class_map: assert property (rx_hdr_valid |-> (rx_class == npf_pkg::CL_CFG) == (rx_hdr.id >= 8'hb4))
      else $error("packet class wrong");
   a_req_state: assert property (req_q[19:0] == 20'h00000)
      else $error("system id queued as request");
   a_neg_ack: assert property ((res_valid && !ctx_cfg_q && res_code == 8'h00) |=> !$rose(ack_pend_q))
      else $error("positive acknowledgement for data packet");
   a_ack_shape: assert property (ack_take |=> tx_id_q == 8'h00 && tx_len_q == 8'h04 && is_ack_q)
      else $error("acknowledgement header wrong");
   a_tx_lrc: assert property ((tx_load && tst_q == T_HDR && k_q == 8'h00) |=>
      tx_out.data == npf_pkg::lrc(tx_id_q, tx_len_q, tx_crc))
      else $error("sent check byte wrong");
   a_tx_crc_lsb: assert property ((tx_load && tst_q == T_HDR && k_q == 8'h03) |=> tx_out.data == tx_crc[7:0])
      else $error("crc low byte not first");
   a_frame_size: assert property ((tst_q == T_PAY && ld_end) |-> nbytes_q == {1'b0, tx_len_q} + 9'd5)
      else $error("sent size not length plus five");
endmodule // npf_framer
`default_nettype wire

/* npf_host.sv */
// host model: sends frames on the receive link, collects transmitted bytes
// assumes one clock; the bench calls send and put and reads rxq
`timescale 1ns/1ns
`default_nettype none

module npf_host (
   // clock
   input wire logic mclk,
   // link
   output var npf_pkg::npf_byte_t rx_in,
   input wire npf_pkg::npf_byte_t tx_out,
   output logic tx_ready
);
   logic [7:0] rxq[$];
   logic slow = 1'b0;
   int cyc = 0;

   initial rx_in = '0;
   initial tx_ready = 1'b1;

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {b[i], 8'h00};
         repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [7:0] lrc(input logic [7:0] id, len, input logic [15:0] c);
      logic [7:0] s;
      s = id + len + c[7:0] + c[15:8];
      return (s ^ 8'hff) + 8'h01;
   endfunction

   // released line shows the inverse of the last byte
   task automatic put(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge mclk);
         rx_in <= '{1'b1, b[i]};
      end
      @(posedge mclk);
      rx_in <= '{1'b0, ~b[b.size() - 1]};
   endtask

   task automatic send(input logic [7:0] id, input logic [7:0] pay[$], input logic bad);
      logic [15:0] c;
      logic [7:0] f[$];
      c = crc16(pay) ^ {15'h0000, bad};
      f = '{lrc(id, 8'(pay.size()), c), id, 8'(pay.size()), c[7:0], c[15:8]};
      foreach (pay[i]) f.push_back(pay[i]);
      put(f);
   endtask

   // slow host stalls every other cycle
   always @(posedge mclk) begin
      cyc++;
      if (tx_out.valid && tx_ready) rxq.push_back(tx_out.data);
      tx_ready <= !slow || cyc[0];
   end
endmodule // npf_host
`default_nettype wire

/* tb_nav_binary_packet_framer.sv */
// self-checking bench for the packet framer
// assumes npf_host on the link; the bench plays the device side
`timescale 1ns/1ns
`default_nettype none

module tb_nav_binary_packet_framer;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   npf_pkg::npf_byte_t rx_in, tx_out, rx_pay;
   npf_pkg::npf_byte_t src_byte = '0;
   npf_pkg::npf_hdr_t rx_hdr, hdr_q;
   npf_pkg::npf_class_t rx_class, cls_q;
   logic tx_ready, rx_hdr_valid, src_req, tov_strobe;
   logic res_valid = 1'b0, src_ack = 1'b0, cfg_wr = 1'b0;
   logic [7:0] res_code = 8'h00, src_len = 8'h00, src_id, cfg_id = 8'h00, cur = 8'h00;
   logic [0:0] cfg_slot = 1'b0;
   logic [15:0] cfg_period = 16'h0000;
   logic [7:0] req_ids[$];
   logic [7:0] payq[$];
   int miscompares = 0, num_checks = 0, cyc = 0, n_tov = 0, n_hdr = 0, busy = 0;

   always #4 mclk = ~mclk;

   npf_framer #(.TICK_CYC(20)) i_dut (.mclk(mclk), .rstn(rstn), .rx_in(rx_in), .tx_out(tx_out),
      .tx_ready(tx_ready), .rx_hdr(rx_hdr), .rx_hdr_valid(rx_hdr_valid), .rx_class(rx_class),
      .rx_pay(rx_pay), .res_valid(res_valid), .res_code(res_code), .src_req(src_req),
      .src_id(src_id), .src_ack(src_ack), .src_len(src_len), .src_byte(src_byte),
      .tov_strobe(tov_strobe), .cfg_wr(cfg_wr), .cfg_slot(cfg_slot), .cfg_id(cfg_id),
      .cfg_period(cfg_period));
   npf_host i_host (.mclk(mclk), .rx_in(rx_in), .tx_out(tx_out), .tx_ready(tx_ready));

   // monitors and device-side payload source: payload of id x is {x, ~x}
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         $display("ERROR t=%0t timeout got=%h exp=%h", $time, cyc, 20000);
         miscompares++;
         report_and_stop();
      end
      if (tov_strobe) n_tov++;
      if (rx_hdr_valid) begin
         n_hdr++;
         hdr_q = rx_hdr;
         cls_q = rx_class;
      end
      if (rx_pay.valid) payq.push_back(rx_pay.data);
      src_ack <= 1'b0;
      src_byte <= '0;
      if (busy > 0) busy <= busy - 1;
      if (busy == 3 || busy == 2) src_byte <= '{1'b1, busy == 3 ? cur : ~cur};
      if (busy == 0 && src_req) begin
         src_ack <= 1'b1;
         src_len <= 8'h02;
         cur <= src_id;
         busy <= 3;
         req_ids.push_back(src_id);
      end
   end

   task automatic report_and_stop();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic wait_gt(ref int v, input int n0);
      int k = 0;
      while (v <= n0 && k < 1200) begin
         @(negedge mclk);
         k++;
      end
      if (v <= n0) begin
         $display("ERROR t=%0t wait got=%h exp=%h", $time, v, n0 + 1);
         miscompares++;
      end
   endtask

   task automatic wait_q(input int n);
      int k = 0;
      while (i_host.rxq.size() < n && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      if (i_host.rxq.size() < n) begin
         $display("ERROR t=%0t bytes got=%h exp=%h", $time, i_host.rxq.size(), n);
         miscompares++;
      end
   endtask

   task automatic get_frame(output logic [7:0] id, output logic [7:0] pay[$]);
      logic [7:0] h[$];
      wait_q(5);
      h = i_host.rxq[0:4];
      wait_q(5 + h[2]);
      pay = i_host.rxq[5:4 + h[2]];
      id = h[1];
      chk(h[0], i_host.lrc(h[1], h[2], {h[4], h[3]}));
      chk({h[4], h[3]}, i_host.crc16(pay));
      repeat (5 + pay.size()) void'(i_host.rxq.pop_front());
   endtask

   task automatic expect_ack(input logic [7:0] pid, input logic [15:0] c, input logic [7:0] code);
      logic [7:0] id;
      logic [7:0] p[$];
      get_frame(id, p);
      chk({id, 8'(p.size())}, 16'h0004);
      chk({p[0], p[1], p[2], p[3]}, {pid, c[7:0], c[15:8], code});
   endtask

   task automatic result(input logic [7:0] code);
      @(posedge mclk);
      res_valid <= 1'b1;
      res_code <= code;
      @(posedge mclk);
      res_valid <= 1'b0;
   endtask

   task automatic cfg(input logic s, input logic [7:0] id);
      @(posedge mclk);
      cfg_wr <= 1'b1;
      cfg_slot <= s;
      cfg_id <= id;
      @(posedge mclk);
      cfg_wr <= 1'b0;
   endtask

   task automatic t_periodic();
      logic [7:0] id;
      logic [7:0] p[$];
      int c0;
      wait_gt(n_tov, 0);
      c0 = cyc;
      for (int i = 0; i < 2; i++) begin
         get_frame(id, p);
         chk(id, i ? 8'h1c : 8'h14);
         chk({p[0], p[1]}, {id, ~id});
      end
      chk({n_tov, req_ids.size()}, {32'd1, 32'd2});
      wait_gt(n_tov, 1);
      chk(cyc - c0, 1000);
      cfg(1'b0, 8'h14);
      cfg(1'b1, 8'h1c);
      repeat (100) @(negedge mclk);
      i_host.rxq.delete();
      $display("periodic done");
   endtask

   task automatic t_cfg();
      logic [7:0] p[$] = '{8'h11, 8'h22, 8'h33};
      int n0 = n_hdr;
      payq.delete();
      i_host.send(8'hb4, p, 1'b0);
      wait_gt(n_hdr, n0);
      chk(hdr_q, {8'hb4, 8'h03, i_host.crc16(p)});
      repeat (5) @(negedge mclk);
      chk({payq.size(), payq[0], payq[1], payq[2]}, 56'h3112233);
      result(8'h00);
      expect_ack(8'hb4, i_host.crc16(p), 8'h00);
      $display("config done");
   endtask

   task automatic t_codes();
      logic [7:0] ids[7] = '{8'h13, 8'h14, 8'hb3, 8'hb4, 8'hff, 8'h05, 8'h32};
      logic [7:0] p[$];
      npf_pkg::npf_class_t cls;
      int n0;
      for (int i = 0; i < 7; i++) begin
         p.delete();
         repeat (i % 3) p.push_back(8'(i));
         cls = ids[i] >= 8'hb4 ? npf_pkg::CL_CFG : ids[i] >= 8'h14 ? npf_pkg::CL_STATE : npf_pkg::CL_SYS;
         n0 = n_hdr;
         i_host.send(ids[i], p, 1'b0);
         wait_gt(n_hdr, n0);
         chk(cls_q, cls);
         result(8'(i));
         if (cls == npf_pkg::CL_CFG || i != 0) expect_ack(ids[i], i_host.crc16(p), 8'(i));
         else begin
            repeat (40) @(negedge mclk);
            chk(i_host.rxq.size(), 0);
         end
      end
      $display("codes done");
   endtask

   task automatic t_bad();
      logic [7:0] p[$] = '{8'h01, 8'h02};
      logic [7:0] g[$] = '{8'h55};
      int n0 = n_hdr;
      i_host.put(g);
      i_host.send(8'h32, p, 1'b1);
      i_host.send(8'h20, p, 1'b0);
      wait_gt(n_hdr, n0);
      repeat (30) @(negedge mclk);
      chk({n_hdr - n0, hdr_q.id}, {32'd1, 8'h20});
      $display("bad crc done");
   endtask

   task automatic t_req();
      logic [7:0] r[$] = '{8'h1c, 8'h05, 8'h14};
      logic [7:0] id;
      logic [7:0] p[$];
      int n0 = n_hdr;
      i_host.slow = 1'b1;
      req_ids.delete();
      i_host.send(8'h01, r, 1'b0);
      for (int i = 0; i < 2; i++) begin
         get_frame(id, p);
         chk({id, p[0], p[1]}, {i ? 8'h14 : 8'h1c, id, ~id});
      end
      repeat (40) @(negedge mclk);
      chk({n_hdr - n0, req_ids.size(), i_host.rxq.size()}, {32'd0, 32'd2, 32'd0});
      i_host.slow = 1'b0;
      $display("request done");
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      t_periodic();
      t_cfg();
      t_codes();
      t_bad();
      t_req();
      report_and_stop();
   end
endmodule // tb_nav_binary_packet_framer
`default_nettype wire
